// *** logic/cfs_byte_port.sv ***
module cfs_byte_port
    import cfs_pkg::*;
(
    // clock and reset
    input wire logic clock,
    input wire logic nrst,
    // register port
    input wire cfs_req_t req,
    output logic [31:0] regRdata,
    // flash pins
    output cfs_pins_t pins,
    input wire logic flashMiso
);

    // ---------------------------------------------------------------
    // input sampling
    // ---------------------------------------------------------------
    logic misoSync;

    cfs_sync u_miso_sync (
        .clock(clock),
        .nrst(nrst),
        .asyncIn(flashMiso),
        .syncOut(misoSync)
    );

    // ---------------------------------------------------------------
    // state
    // ---------------------------------------------------------------
    cfs_state_t state_ff;
    cfs_state_t nxt_state;
    logic [1:0] phase_ff;
    logic [1:0] nxt_phase;
    logic [2:0] bitCnt_ff;
    logic [2:0] nxt_bitCnt;
    logic [7:0] shift_ff;
    logic [7:0] nxt_shift;
    logic byteValid_ff;
    logic nxt_byteValid;
    logic cs_ff;
    logic nxt_cs;
    logic sck_ff;
    logic nxt_sck;
    logic mosi_ff;
    logic nxt_mosi;
    logic [31:0] rdata_ff;
    logic [31:0] nxt_rdata;

    logic busy;
    logic dataWrite;
    logic ctrlWrite;
    logic startXfer;
    logic lastPhase;

    assign busy = (state_ff == CFS_SHIFT);
    assign dataWrite = req.write && (req.addr == CFS_DATA_OFS);
    assign ctrlWrite = req.write && (req.addr == CFS_CONTROL_OFS);
    // writes during a byte are dropped so the shifter cannot be torn
    assign startXfer = dataWrite && !busy;
    assign lastPhase = (phase_ff == CFS_PHASE_LAST);

    // ---------------------------------------------------------------
    // shifter
    // ---------------------------------------------------------------
    always_comb begin
        nxt_state = state_ff;
        nxt_phase = phase_ff;
        nxt_bitCnt = bitCnt_ff;
        nxt_shift = shift_ff;
        nxt_byteValid = byteValid_ff;
        nxt_sck = sck_ff;
        nxt_mosi = mosi_ff;
        unique case (state_ff)
            CFS_IDLE: begin
                nxt_sck = 1'b0;
                if (startXfer) begin
                    nxt_state = CFS_SHIFT;
                    nxt_shift = req.wdata[7:0];
                    nxt_mosi = req.wdata[7];
                    nxt_byteValid = 1'b0;
                    nxt_phase = CFS_PHASE_FIRST;
                    nxt_bitCnt = CFS_BIT_FIRST;
                end
            end
            CFS_SHIFT: begin
                // low one cycle, high two: mode 0, flash samples on rise
                if (phase_ff == CFS_PHASE_FIRST) begin
                    nxt_sck = 1'b1;
                end
                if (lastPhase) begin
                    // late sample hides the two-stage input delay
                    nxt_shift = {shift_ff[6:0], misoSync};
                    nxt_mosi = shift_ff[6];
                    nxt_sck = 1'b0;
                    nxt_phase = CFS_PHASE_FIRST;
                    nxt_bitCnt = bitCnt_ff + 3'h1;
                    if (bitCnt_ff == CFS_BIT_LAST) begin
                        nxt_state = CFS_IDLE;
                        nxt_byteValid = 1'b1;
                    end
                end else begin
                    nxt_phase = phase_ff + 2'h1;
                end
            end
        endcase
    end

    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            state_ff <= CFS_IDLE;
            phase_ff <= CFS_PHASE_FIRST;
            bitCnt_ff <= CFS_BIT_FIRST;
            shift_ff <= CFS_DATA_RESET;
            byteValid_ff <= CFS_VALID_RESET;
            sck_ff <= 1'b0;
            mosi_ff <= 1'b0;
        end else begin
            state_ff <= nxt_state;
            phase_ff <= nxt_phase;
            bitCnt_ff <= nxt_bitCnt;
            shift_ff <= nxt_shift;
            byteValid_ff <= nxt_byteValid;
            sck_ff <= nxt_sck;
            mosi_ff <= nxt_mosi;
        end
    end

    // ---------------------------------------------------------------
    // registers
    // ---------------------------------------------------------------
    always_comb begin
        nxt_cs = cs_ff;
        nxt_rdata = rdata_ff;
        if (ctrlWrite) begin
            nxt_cs = req.wdata[CFS_CS_BIT];
        end
        if (req.read) begin
            nxt_rdata = CFS_RDATA_RESET;
            if (req.addr == CFS_DATA_OFS) begin
                nxt_rdata[7:0] = shift_ff;
            end else if (req.addr == CFS_CONTROL_OFS) begin
                nxt_rdata[CFS_CS_BIT] = cs_ff;
                nxt_rdata[CFS_BUSY_BIT] = busy;
                nxt_rdata[CFS_VALID_BIT] = byteValid_ff;
            end
        end
    end

    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            cs_ff <= CFS_CS_RESET;
            rdata_ff <= CFS_RDATA_RESET;
        end else begin
            cs_ff <= nxt_cs;
            rdata_ff <= nxt_rdata;
        end
    end

    assign regRdata = rdata_ff;
    // one driver for the whole struct: members are not separate variables
    assign pins = '{sck: sck_ff, mosi: mosi_ff, csN: cs_ff};

    // ---------------------------------------------------------------
    // assertions
    // ---------------------------------------------------------------
    a_write_clears_valid: assert property (@(posedge clock)
        disable iff (!nrst) startXfer |=> !byteValid_ff && busy)
        else $error("data write did not clear valid and start");

    a_busy_length: assert property (@(posedge clock)
        disable iff (!nrst) startXfer |=> busy ##23 busy ##1 !busy)
        else $error("busy window is not 24 cycles");

    a_valid_on_done: assert property (@(posedge clock)
        disable iff (!nrst) $fell(busy) |-> byteValid_ff)
        else $error("valid not set at end of byte");

    // polling software relies on valid standing until the next byte
    a_valid_holds: assert property (@(posedge clock)
        disable iff (!nrst) byteValid_ff && !startXfer |=> byteValid_ff)
        else $error("valid dropped without a data write");

    a_sck_shape: assert property (@(posedge clock)
        disable iff (!nrst) $rose(pins.sck) |=> pins.sck ##1 !pins.sck)
        else $error("serial clock high time wrong");

    a_sck_idle_low: assert property (@(posedge clock)
        disable iff (!nrst) !busy |-> !pins.sck)
        else $error("serial clock active while idle");

    a_mosi_stable: assert property (@(posedge clock)
        disable iff (!nrst) pins.sck |-> $stable(pins.mosi))
        else $error("mosi moved while clock high");

    a_cs_follows: assert property (@(posedge clock)
        disable iff (!nrst)
        ctrlWrite |=> pins.csN == $past(req.wdata[CFS_CS_BIT]))
        else $error("chip select did not follow write");

    a_data_read: assert property (@(posedge clock)
        disable iff (!nrst) (req.read && req.addr == CFS_DATA_OFS)
        |=> regRdata == {24'h000000, $past(shift_ff)})
        else $error("data read returned wrong byte");

    a_ctrl_read: assert property (@(posedge clock)
        disable iff (!nrst) (req.read && req.addr == CFS_CONTROL_OFS)
        |=> regRdata[31:3] == 29'h00000000
        && regRdata[CFS_BUSY_BIT] == $past(busy))
        else $error("control read wrong");

endmodule

// *** logic/cfs_pkg.sv ***
package cfs_pkg;

    // ---------------------------------------------------------------
    // register map (byte offsets from the card base)
    // ---------------------------------------------------------------
    localparam logic [15:0] CFS_CONTROL_OFS = 16'h0070;
    localparam logic [15:0] CFS_DATA_OFS = 16'h0074;

    // ---------------------------------------------------------------
    // control register fields
    // ---------------------------------------------------------------
    localparam int CFS_CS_BIT = 0;
    localparam int CFS_BUSY_BIT = 1;
    localparam int CFS_VALID_BIT = 2;
    localparam logic CFS_CS_RESET = 1'b1;
    localparam logic CFS_VALID_RESET = 1'b0;
    localparam logic [7:0] CFS_DATA_RESET = 8'h00;
    localparam logic [31:0] CFS_RDATA_RESET = 32'h00000000;

    // ---------------------------------------------------------------
    // shift timing
    // ---------------------------------------------------------------
    localparam int CFS_BUS_CLOCK_HZ = 10000000;
    localparam int CFS_SCK_DIV = 3;
    localparam int CFS_SCK_HZ = CFS_BUS_CLOCK_HZ / CFS_SCK_DIV;
    localparam logic [1:0] CFS_PHASE_FIRST = 2'h0;
    localparam logic [1:0] CFS_PHASE_RISE = 2'h1;
    localparam logic [1:0] CFS_PHASE_LAST = 2'(CFS_SCK_DIV - 1);
    localparam logic [2:0] CFS_BIT_FIRST = 3'h0;
    localparam logic [2:0] CFS_BIT_LAST = 3'h7;
    localparam int CFS_BYTE_CYCLES = 8 * CFS_SCK_DIV;

    typedef enum logic {
        CFS_IDLE,
        CFS_SHIFT
    } cfs_state_t;

    // serial pins toward the flash
    typedef struct packed {
        logic sck;
        logic mosi;
        logic csN;
    } cfs_pins_t;

    // register-side request
    typedef struct packed {
        logic [15:0] addr;
        logic write;
        logic read;
        logic [31:0] wdata;
    } cfs_req_t;

endpackage

// *** logic/cfs_sync.sv ***
module cfs_sync
(
    // clock and reset
    input wire logic clock,
    input wire logic nrst,
    // level in and out
    input wire logic asyncIn,
    output logic syncOut
);

    logic stage1_ff;
    logic stage2_ff;
    logic nxt_stage1;
    logic nxt_stage2;

    always_comb begin
        nxt_stage1 = asyncIn;
        nxt_stage2 = stage1_ff;
    end

    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            stage1_ff <= 1'b0;
            stage2_ff <= 1'b0;
        end else begin
            stage1_ff <= nxt_stage1;
            stage2_ff <= nxt_stage2;
        end
    end

    assign syncOut = stage2_ff;

endmodule

// *** tb/cfs_byte_port_bench.sv ***
module cfs_byte_port_bench
    import cfs_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;

    logic clock = 1'b0;
    logic nrst = 1'b0;
    cfs_req_t req = '0;
    logic [31:0] regRdata;
    cfs_pins_t pins;
    logic flashMiso;
    logic [7:0] reply = 8'h00;
    logic [7:0] rxByte;
    logic [31:0] expQ[$];
    logic pend1 = 1'b0;
    logic pend2 = 1'b0;
    logic csState = 1'b1;
    int miscompares = 0;
    int checks = 0;
    int cycles = 0;
    int seed = 32'h6484;
    time lastRise = 0;

    always #50 clock = ~clock;

    cfs_byte_port cfs_byte_port_i (
        .clock(clock),
        .nrst(nrst),
        .req(req),
        .regRdata(regRdata),
        .pins(pins),
        .flashMiso(flashMiso)
    );

    cfs_flash_model cfs_flash_model_i (
        .pins(pins),
        .reply(reply),
        .flashMiso(flashMiso),
        .rxByte(rxByte)
    );

    // ---------------------------------------------------------------
    // checking and bus tasks
    // ---------------------------------------------------------------
    task automatic chk(input string what, input logic [31:0] seen,
                       input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic give_verdict;
        $display("checks %0d miscompares %0d", checks, miscompares);
        if (miscompares == 0 && checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    task automatic wr(input logic [15:0] a, input logic [31:0] d);
        @(negedge clock);
        req.addr = a;
        req.wdata = d;
        req.write = 1'b1;
        @(negedge clock);
        req.write = 1'b0;
    endtask

    task automatic rd(input logic [15:0] a, input logic [31:0] e);
        @(negedge clock);
        req.addr = a;
        req.read = 1'b1;
        expQ.push_back(e);
        @(negedge clock);
        req.read = 1'b0;
    endtask

    // upper bits random: only the select bit may take effect
    task automatic setCs(input logic c);
        logic [31:0] w;
        w = $random(seed);
        w[CFS_CS_BIT] = c;
        wr(CFS_CONTROL_OFS, w);
        csState = c;
    endtask

    task automatic xfer(input logic [7:0] d, input logic dup);
        logic [7:0] r;
        r = 8'($random(seed));
        reply = r;
        wr(CFS_DATA_OFS, {24'h0, d});
        if (dup) begin
            wr(CFS_DATA_OFS, {24'h0, ~d});
        end
        rd(CFS_CONTROL_OFS, {29'h0, 2'h1, csState});
        repeat (24) @(negedge clock);
        rd(CFS_CONTROL_OFS, {29'h0, 2'h2, csState});
        rd(CFS_DATA_OFS, {24'h0, r});
        chk("flashRx", {24'h0, rxByte}, {24'h0, d});
        chk("csN", {31'h0, pins.csN}, {31'h0, csState});
    endtask

    // ---------------------------------------------------------------
    // output watchers
    // ---------------------------------------------------------------
    always @(posedge clock) begin
        pend1 <= req.read;
        pend2 <= pend1;
        cycles <= cycles + 1;
    end

    // read answer stands until the next read, so one cycle late is safe
    always @(negedge clock) begin
        if (pend2) begin
            chk("regRdata", regRdata, expQ.pop_front());
        end
        if (cycles >= 5000) begin
            miscompares++;
            give_verdict();
        end
    end

    always @(posedge pins.sck) begin
        if ($time - lastRise < 1000) begin
            chk("sckPeriod", 32'($time - lastRise), 32'h0000012C);
        end
        lastRise = $time;
    end

    initial begin
        logic [7:0] cmd [4] = '{8'h03, 8'h08, 8'h00, 8'h00};
        repeat (12) @(negedge clock);
        nrst = 1'b1;
        chk("pins", {29'h0, pins}, {29'h0, 3'h1});
        rd(CFS_CONTROL_OFS, 32'h1);
        rd(CFS_DATA_OFS, 32'h0);
        rd(16'h0078, 32'h0);
        setCs(1'b0);
        rd(CFS_CONTROL_OFS, 32'h0);
        // read command at the sector-aligned user image base
        for (int i = 0; i < 4; i++) begin
            xfer(cmd[i], i == 1);
        end
        xfer(8'hFF, 1'b0);
        for (int i = 0; i < 3; i++) begin
            xfer(8'($random(seed)), 1'b0);
        end
        setCs(1'b1);
        rd(CFS_CONTROL_OFS, 32'h5);
        // reads from the application area, then from the boot block
        for (int j = 0; j < 2; j++) begin
            setCs(1'b0);
            xfer(8'h03, 1'b0);
            xfer(j ? 8'h00 : 8'h0E, 1'b0);
            xfer(8'h00, 1'b0);
            xfer(8'h00, 1'b0);
            xfer(8'($random(seed)), 1'b0);
            setCs(1'b1);
        end
        // reset in mid-byte must drop busy, valid and the pins
        setCs(1'b0);
        wr(CFS_DATA_OFS, 32'h5A);
        repeat (5) @(negedge clock);
        nrst = 1'b0;
        repeat (2) @(negedge clock);
        nrst = 1'b1;
        chk("pins", {29'h0, pins}, {29'h0, 3'h1});
        rd(CFS_CONTROL_OFS, 32'h1);
        repeat (4) @(negedge clock);
        give_verdict();
    end
endmodule

// *** tb/cfs_flash_model.sv ***
module cfs_flash_model
    import cfs_pkg::*;
(
    // pins from the port
    input wire cfs_pins_t pins,
    // byte the flash answers with, byte it took in
    input wire logic [7:0] reply,
    output logic flashMiso,
    output logic [7:0] rxByte
);
    timeunit 1ns;
    timeprecision 1ns;

    logic [2:0] bitCnt = 3'h0;

    initial rxByte = 8'h00;

    // mode 0: take mosi on the rise, next bit out after the fall
    always @(posedge pins.sck) begin
        if (!pins.csN) begin
            rxByte <= {rxByte[6:0], pins.mosi};
        end
    end

    // deselect restarts the bit count, as a cut frame must not skew the next
    always @(negedge pins.sck or posedge pins.csN) begin
        if (pins.csN) begin
            bitCnt <= 3'h0;
        end else begin
            bitCnt <= bitCnt + 3'h1;
        end
    end

    // deselected line shows the inverse so a stale bit never passes
    assign flashMiso = pins.csN ? ~reply[3'h7 - bitCnt] : reply[3'h7 - bitCnt];
endmodule
